/* File: src/fws_pkg.sv */
// package of constants and types for the fail-safe watchdog supervisor
package fws_pkg;
  localparam int NumOut = 4;
  // watchdog periods in microseconds, one per period setting
  localparam int WdPeriod0Us = 10000;
  localparam int WdPeriod1Us = 30000;
  localparam int WdPeriod2Us = 50000;
  localparam int WdPeriod3Us = 100000;
  localparam int ClkPeriodNs = 100;
  localparam logic [19:0] WdCycles0 = 20'(WdPeriod0Us * 1000 / ClkPeriodNs);
  localparam logic [19:0] WdCycles1 = 20'(WdPeriod1Us * 1000 / ClkPeriodNs);
  localparam logic [19:0] WdCycles2 = 20'(WdPeriod2Us * 1000 / ClkPeriodNs);
  localparam logic [19:0] WdCycles3 = 20'(WdPeriod3Us * 1000 / ClkPeriodNs);
  // overcurrent time choices in microseconds, indexed by time select
  localparam int OcTime0Us = 150;
  localparam int OcTime1Us = 1200;
  localparam int OcTime2Us = 2500;
  localparam int OcTime3Us = 5000;
  localparam logic [15:0] OcCycles0 = 16'(OcTime0Us * 1000 / ClkPeriodNs);
  localparam logic [15:0] OcCycles1 = 16'(OcTime1Us * 1000 / ClkPeriodNs);
  localparam logic [15:0] OcCycles2 = 16'(OcTime2Us * 1000 / ClkPeriodNs);
  localparam logic [15:0] OcCycles3 = 16'(OcTime3Us * 1000 / ClkPeriodNs);
  // default settings after reset; all but the watchdog period also on fail-safe entry
  localparam logic [2:0] OcLowLevelDef  = 3'h0;
  localparam logic       OcHighLevelDef = 1'h0;
  localparam logic [1:0] OcTimeDef      = 2'h0;
  localparam logic [3:0] OtLatchDef     = 4'h0;
  localparam logic [1:0] WdPeriodDef    = 2'h0;
  // bit positions in status words
  localparam int WdTimeoutBit  = 2;
  localparam int OvFaultBit    = 1;
  localparam int OvWarnBit     = 13;
  localparam int ToggleBit     = 15;
  // fail-safe select levels
  typedef enum logic [1:0] {
    FWS_SEL_GND  = 2'h0,
    FWS_SEL_OFF  = 2'h1,
    FWS_SEL_OUT0 = 2'h2,
    FWS_SEL_OPEN = 2'h3
  } fws_sel_t;
  localparam logic [3:0] PatOff  = 4'h0;
  localparam logic [3:0] PatOut0 = 4'h1;
  localparam logic [3:0] PatOpen = 4'h5;
  // supervisor modes
  typedef enum logic [2:0] {
    FWS_IDLE  = 3'b001,
    FWS_ARMED = 3'b010,
    FWS_SAFE  = 3'b100
  } fws_mode_t;
endpackage : fws_pkg

/* File: src/fws_ch_protect.sv */
// per-output protection: overtemperature, overcurrent, overvoltage gating
`timescale 1ns/1ps
module fws_ch_protect
  import fws_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       cmdOn,
  input  wire logic       otLatchCfg,
  input  wire logic       overTemp,
  input  wire logic       overTempHys,
  input  wire logic       ocLowHit,
  input  wire logic       ocHighHit,
  input  wire logic [15:0] ocLimit,
  input  wire logic       ovBlock,
  input  wire logic       failSafe,
  input  wire logic       selGndPulse,
  output      logic       drive,
  output      logic       otLatched,
  output      logic       ocLatched,
  output      logic       otActive
);
  typedef struct packed {
    logic        cmdPrev;
    logic        otLat;
    logic        otNl;
    logic        ocLat;
    logic [15:0] ocCnt;
  } fws_ch_t;
  fws_ch_t st_reg, st_next;

  // next-state for latches and timer
  always_comb begin
    st_next = st_reg;
    st_next.cmdPrev = cmdOn;
    if (cmdOn && !st_reg.cmdPrev && !failSafe) begin
      st_next.otLat = 1'b0;
      st_next.ocLat = 1'b0;
    end
    if (selGndPulse) begin
      st_next.otLat = 1'b0;
    end
    if (overTemp && cmdOn) begin
      if (otLatchCfg && !failSafe) st_next.otNl = 1'b1;
      else st_next.otLat = 1'b1;
    end else if (!overTempHys) begin
      st_next.otNl = 1'b0;
    end
    if (ocLowHit && cmdOn && !st_reg.ocLat) begin
      if (st_reg.ocCnt >= ocLimit) st_next.ocLat = 1'b1;
      else st_next.ocCnt = st_reg.ocCnt + 16'h1;
    end else begin
      st_next.ocCnt = 16'h0;
    end
    if (ocHighHit && cmdOn) st_next.ocLat = 1'b1;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) st_reg <= '0;
    else st_reg <= st_next;
  end

  assign drive = cmdOn && !st_reg.otLat && !st_reg.otNl && !st_reg.ocLat
                 && !ovBlock;
  assign otLatched = st_reg.otLat;
  assign ocLatched = st_reg.ocLat;
  assign otActive  = st_reg.otNl | st_reg.otLat;
endmodule : fws_ch_protect

/* File: src/fws_supervisor.sv */
// watchdog, fail-safe mode and fault reporting for a four-output switch
`timescale 1ns/1ps
module fws_supervisor
  import fws_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        logicSupplyOk,
  input  wire logic        wakePin,
  input  wire logic        resetPin,
  input  wire logic [1:0]  failsafe_select_input,
  input  wire logic [3:0]  direct_drive_inputs,
  input  wire logic        spiWordValid,
  input  wire logic [15:0] spiWord,
  input  wire logic [3:0]  spiOutCmd,
  input  wire logic [1:0]  watchdog_period_setting,
  input  wire logic [2:0]  overcurrent_low_level_sel,
  input  wire logic        overcurrent_high_level_sel,
  input  wire logic [1:0]  overcurrent_time_sel,
  input  wire logic [3:0]  overtemp_latch_cfg,
  input  wire logic        overvoltage_protect_off,
  input  wire logic        cfgWrite,
  input  wire logic [3:0]  overTemp,
  input  wire logic [3:0]  overTempHys,
  input  wire logic [3:0]  ocLowLevelHit,
  input  wire logic [3:0]  ocHighLevelHit,
  input  wire logic        overVoltage,
  input  wire logic        otherFault,
  output      logic [3:0]  switched_outputs,
  output      logic        fault_flag_n,
  output      logic        watchdog_timeout_flag,
  output      logic [3:0]  overtemp_fault_status,
  output      logic [3:0]  overcurrent_fault_status,
  output      logic        overvoltage_fault_status,
  output      logic        overvoltageWarn,
  output      logic [15:0] faultWord,
  output      logic [2:0]  ocLowLevelActive,
  output      logic        ocHighLevelActive
);
  typedef struct packed {
    fws_mode_t   mode;
    logic        wakePrev;
    logic        rstPrev;
    logic        selGndPrev;
    logic        togglePrev;
    logic [19:0] wdCnt;
    logic [1:0]  wdPer;
    logic [2:0]  ocLow;
    logic        ocHigh;
    logic [1:0]  ocTime;
    logic [3:0]  otCfg;
    logic        ovOff;
    logic [3:0]  otStat;
    logic [3:0]  ocStat;
    logic        ovStat;
    logic [3:0]  outs;
    logic        flagN;
    logic        ovWarn;
    logic [15:0] fword;
  } fws_st_t;
  fws_st_t st_reg, st_next;

  logic [3:0] chDrive, chOtLat, chOcLat, chOtAct, cmdOn;
  logic       selGnd, failSafe, selGndPulse, ovBlock;
  logic [15:0] ocLimit;

  // watchdog period in cycles from setting
  function automatic logic [19:0] fws_wd_cycles(input logic [1:0] sel);
    case (sel)
      2'h0:    fws_wd_cycles = WdCycles0;
      2'h1:    fws_wd_cycles = WdCycles1;
      2'h2:    fws_wd_cycles = WdCycles2;
      default: fws_wd_cycles = WdCycles3;
    endcase
  endfunction : fws_wd_cycles

  // overcurrent time in cycles from select
  function automatic logic [15:0] fws_oc_cycles(input logic [1:0] sel);
    case (sel)
      2'h0:    fws_oc_cycles = OcCycles0;
      2'h1:    fws_oc_cycles = OcCycles1;
      2'h2:    fws_oc_cycles = OcCycles2;
      default: fws_oc_cycles = OcCycles3;
    endcase
  endfunction : fws_oc_cycles

  // shared control terms
  assign selGnd      = (failsafe_select_input == FWS_SEL_GND);
  assign failSafe    = (st_reg.mode == FWS_SAFE);
  assign selGndPulse = failSafe && selGnd;
  assign ovBlock     = overVoltage && !st_reg.ovOff;
  assign ocLimit     = fws_oc_cycles(st_reg.ocTime);
  // spi commands lost with the logic supply
  assign cmdOn       = direct_drive_inputs
                       | (spiOutCmd & {4{logicSupplyOk}});

  // per-output protection instances
  for (genvar i = 0; i < NumOut; i++) begin : g_ch
    fws_ch_protect u_ch (
      .clk         (clk),
      .rst_b       (rst_b),
      .cmdOn       (cmdOn[i]),
      .otLatchCfg  (st_reg.otCfg[i]),
      .overTemp    (overTemp[i]),
      .overTempHys (overTempHys[i]),
      .ocLowHit    (ocLowLevelHit[i]),
      .ocHighHit   (ocHighLevelHit[i]),
      .ocLimit     (ocLimit),
      .ovBlock     (ovBlock),
      .failSafe    (failSafe),
      .selGndPulse (selGndPulse),
      .drive       (chDrive[i]),
      .otLatched   (chOtLat[i]),
      .ocLatched   (chOcLat[i]),
      .otActive    (chOtAct[i])
    );
  end

  // mode, watchdog, settings and fault bits
  always_comb begin
    logic       toggled;
    logic       wdExpired;
    logic [3:0] pat;
    toggled   = 1'b0;
    wdExpired = 1'b0;
    pat       = PatOff;
    st_next = st_reg;
    st_next.wakePrev   = wakePin;
    st_next.rstPrev    = resetPin;
    st_next.selGndPrev = selGnd;
    // word arrives whole, toggle is bit 15
    if (spiWordValid) begin
      st_next.togglePrev = spiWord[ToggleBit];
      toggled = (spiWord[ToggleBit] != st_reg.togglePrev);
    end
    if (cfgWrite) begin
      st_next.wdPer  = watchdog_period_setting;
      st_next.ocLow  = overcurrent_low_level_sel;
      st_next.ocHigh = overcurrent_high_level_sel;
      st_next.ocTime = overcurrent_time_sel;
      st_next.otCfg  = overtemp_latch_cfg;
      st_next.ovOff  = overvoltage_protect_off;
    end
    if (toggled || st_reg.mode != FWS_ARMED) st_next.wdCnt = 20'h0;
    else st_next.wdCnt = st_reg.wdCnt + 20'h1;
    wdExpired = (st_reg.mode == FWS_ARMED) && !toggled
                && (st_reg.wdCnt >= fws_wd_cycles(st_reg.wdPer) - 20'h1);
    case (st_reg.mode)
      FWS_IDLE: begin
        // arm on rising wake or reset
        if (!selGnd && ((wakePin && !st_reg.wakePrev)
                        || (resetPin && !st_reg.rstPrev)))
          st_next.mode = FWS_ARMED;
      end
      FWS_ARMED: begin
        if (selGnd) begin
          st_next.mode = FWS_IDLE;
        end else if (wdExpired) begin
          st_next.mode = FWS_SAFE;
          st_next.ocLow  = OcLowLevelDef;
          st_next.ocHigh = OcHighLevelDef;
          st_next.ocTime = OcTimeDef;
          st_next.otCfg  = OtLatchDef;
        end
      end
      FWS_SAFE: begin
        // both pins fall together, or ground
        if (selGnd || (!wakePin && !resetPin && st_reg.wakePrev
                       && st_reg.rstPrev))
          st_next.mode = FWS_IDLE;
        else if (cfgWrite) begin
          st_next.ocLow  = OcLowLevelDef;
          st_next.ocHigh = OcHighLevelDef;
          st_next.ocTime = OcTimeDef;
          st_next.otCfg  = OtLatchDef;
        end
      end
      default: st_next.mode = FWS_IDLE;
    endcase
    if (spiWordValid) begin
      st_next.otStat = 4'h0;
      st_next.ocStat = 4'h0;
      st_next.ovStat = 1'b0;
    end
    st_next.otStat = st_next.otStat | chOtAct;
    st_next.ocStat = st_next.ocStat | chOtLat | chOcLat;
    if (overVoltage) st_next.ovStat = 1'b1;
    st_next.ovWarn = overVoltage;
    case (failsafe_select_input)
      FWS_SEL_OUT0: pat = PatOut0;
      FWS_SEL_OPEN: pat = PatOpen;
      default:      pat = PatOff;
    endcase
    if (st_next.mode == FWS_SAFE) st_next.outs = pat & ~(chOtLat | chOcLat)
                                                 & {4{!ovBlock}};
    else st_next.outs = chDrive;
    // flag low on any fault except the watchdog timeout; latched held
    st_next.flagN = !(overVoltage || otherFault || (|chOtAct)
                      || (|chOcLat));
    st_next.fword = 16'h0;
    st_next.fword[WdTimeoutBit] = (st_next.mode == FWS_SAFE);
    st_next.fword[OvFaultBit]   = st_next.ovStat;
    st_next.fword[OvWarnBit]    = overVoltage;
    st_next.fword[11:8]         = st_next.otStat;
    st_next.fword[7:4]          = st_next.ocStat;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg        <= '0;
      st_reg.mode   <= FWS_IDLE;
      st_reg.flagN  <= 1'b1;
      st_reg.wdPer  <= WdPeriodDef;
    end else if (!logicSupplyOk) begin
      st_reg        <= '0;
      st_reg.mode   <= (st_reg.mode == FWS_IDLE) ? FWS_IDLE : st_next.mode;
      st_reg.wdCnt  <= st_next.wdCnt;
      st_reg.wakePrev <= wakePin;
      st_reg.rstPrev  <= resetPin;
      st_reg.outs   <= st_next.outs;
      st_reg.flagN  <= st_next.flagN;
      // watchdog keeps working, timeout bit tracks mode
      st_reg.togglePrev <= st_next.togglePrev;
      st_reg.fword[WdTimeoutBit] <= st_next.fword[WdTimeoutBit];
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state register
  assign switched_outputs         = st_reg.outs;
  assign fault_flag_n             = st_reg.flagN;
  assign watchdog_timeout_flag    = st_reg.fword[WdTimeoutBit];
  assign overtemp_fault_status    = st_reg.otStat;
  assign overcurrent_fault_status = st_reg.ocStat;
  assign overvoltage_fault_status = st_reg.ovStat;
  assign overvoltageWarn          = st_reg.ovWarn;
  assign faultWord                = st_reg.fword;
  // one low and one high level selected
  assign ocLowLevelActive         = st_reg.ocLow;
  assign ocHighLevelActive        = st_reg.ocHigh;
endmodule : fws_supervisor

/* File: test/fws_checker.sv */
// assertion checker on the supervisor's ports
`timescale 1ns/1ps
module fws_checker
  import fws_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        logicSupplyOk,
  input wire logic        wakePin,
  input wire logic        resetPin,
  input wire logic [1:0]  failsafe_select_input,
  input wire logic [3:0]  ocHighLevelHit,
  input wire logic        overVoltage,
  input wire logic        otherFault,
  input wire logic [3:0]  switched_outputs,
  input wire logic        fault_flag_n,
  input wire logic        watchdog_timeout_flag,
  input wire logic [15:0] faultWord,
  input wire logic [2:0]  ocLowLevelActive
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  gnd_sel_quiet_a: assert property (
    failsafe_select_input == FWS_SEL_GND |=> !watchdog_timeout_flag)
    else $error("timeout flag set with select grounded");
  safe_latched_a: assert property (
    watchdog_timeout_flag && failsafe_select_input != FWS_SEL_GND
    && !(!wakePin && !resetPin && $past(wakePin) && $past(resetPin))
    |=> watchdog_timeout_flag && faultWord[WdTimeoutBit])
    else $error("fail-safe left without release");
  open_pattern_a: assert property (
    watchdog_timeout_flag && $past(watchdog_timeout_flag, 2) && fault_flag_n
    && $past(failsafe_select_input) == FWS_SEL_OPEN
    |-> switched_outputs == PatOpen)
    else $error("outputs differ from open pattern");
  pin_exit_a: assert property (
    wakePin && resetPin ##1 !wakePin && !resetPin
    |-> ##[1:2] !watchdog_timeout_flag) else $error("safe mode kept");
  flag_low_a: assert property (
    otherFault |-> ##[1:2] !fault_flag_n) else $error("fault flag high");
  ov_warn_a: assert property (
    overVoltage |=> faultWord[OvWarnBit]) else $error("no warning bit");
  oc_high_off_a: assert property (
    $rose(ocHighLevelHit[2]) |-> ##[1:2] !switched_outputs[2])
    else $error("output on after high overcurrent");
  level_default_a: assert property (
    !logicSupplyOk || ($past(watchdog_timeout_flag) && watchdog_timeout_flag)
    |-> ##[0:1] ocLowLevelActive == OcLowLevelDef)
    else $error("low level not default");
endmodule : fws_checker
bind fws_supervisor fws_checker u_chk (.*);

/* File: test/fws_host_model.sv */
// host model: mode pins and watchdog-kicking word source
`timescale 1ns/1ps
module fws_host_model (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        wakeCmd,
  input  wire logic        kickEn,
  input  wire logic        readReq,
  input  wire logic [14:0] payload,
  output      logic        wakePin,
  output      logic        resetPin,
  output      logic        spiWordValid,
  output      logic [15:0] spiWord
);
  logic [5:0] gapCnt_reg;
  logic       toggle_reg;
  // pins together, toggle in time, whole words
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      gapCnt_reg   <= 6'h00;
      toggle_reg   <= 1'b0;
      wakePin      <= 1'b0;
      resetPin     <= 1'b0;
      spiWordValid <= 1'b0;
      spiWord      <= 16'h0000;
    end else begin
      wakePin      <= wakeCmd;
      resetPin     <= wakeCmd;
      gapCnt_reg   <= gapCnt_reg + 6'h01;
      spiWordValid <= 1'b0;
      spiWord      <= ~spiWord; // no stale word between transfers
      if (kickEn && gapCnt_reg == 6'h3F) begin
        toggle_reg   <= ~toggle_reg;
        spiWordValid <= 1'b1;
        spiWord      <= {~toggle_reg, payload};
      end else if (readReq) begin
        spiWordValid <= 1'b1;
        spiWord      <= {toggle_reg, payload};
      end
    end
  end
endmodule : fws_host_model

/* File: test/tb_top.sv */
// self-checking bench for the fail-safe watchdog supervisor
`timescale 1ns/1ps
module tb_top
  import fws_pkg::*;
  ;
  logic        clk, rst_b, logicSupplyOk, cfgWrite, otherFault, overVoltage;
  logic        overcurrent_high_level_sel, overvoltage_protect_off;
  logic        wakeCmd, kickEn, readReq, wakePin, resetPin, spiWordValid;
  logic [1:0]  failsafe_select_input, watchdog_period_setting;
  logic [1:0]  overcurrent_time_sel;
  logic [2:0]  overcurrent_low_level_sel, ocLowLevelActive;
  logic [3:0]  direct_drive_inputs, spiOutCmd, overtemp_latch_cfg, overTemp;
  logic [3:0]  overTempHys, ocLowLevelHit, ocHighLevelHit, switched_outputs;
  logic [3:0]  overtemp_fault_status, overcurrent_fault_status;
  logic        fault_flag_n, watchdog_timeout_flag, overvoltage_fault_status;
  logic        overvoltageWarn, ocHighLevelActive;
  logic [14:0] payload;
  logic [15:0] spiWord, faultWord, rnd;
  int          fail_count, n_compared, cyc, n;
  fws_supervisor u_dut (.*);
  fws_host_model u_host (.*);
  // clock and hang guard
  initial clk = 1'b0;
  always #50 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 120000) begin
      fail_count++;
      $display("MISMATCH t=%0t run limit reached", $time);
      conclude();
    end
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  function automatic logic [3:0] pat(input logic [1:0] s);
    return s == FWS_SEL_OUT0 ? PatOut0 : s == FWS_SEL_OPEN ? PatOpen : PatOff;
  endfunction : pat
  task automatic e(input int k);
    repeat (k) @(posedge clk);
  endtask : e
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic pulse(input int which);
    e(1);
    if (which == 0) readReq <= 1'b1;
    else cfgWrite <= 1'b1;
    e(1);
    readReq <= 1'b0;
    cfgWrite <= 1'b0;
  endtask : pulse
  task automatic reopen(input logic [3:0] m);
    e(1);
    direct_drive_inputs <= ~m;
    e(2);
    direct_drive_inputs <= 4'hF;
    e(3);
  endtask : reopen
  task conclude();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  // main sequence
  initial begin
    {rst_b, cfgWrite, otherFault, overVoltage, overcurrent_high_level_sel,
     overvoltage_protect_off, wakeCmd, kickEn, readReq, watchdog_period_setting,
     overcurrent_time_sel, overcurrent_low_level_sel, direct_drive_inputs,
     spiOutCmd, overtemp_latch_cfg, overTemp, overTempHys, ocLowLevelHit,
     ocHighLevelHit, payload} = '0;
    logicSupplyOk = 1'b1;
    failsafe_select_input = FWS_SEL_OPEN;
    rnd = 16'h005B;
    e(16);
    rst_b <= 1'b1;
    e(2);
    wakeCmd <= 1'b1;
    kickEn <= 1'b1;
    for (n = 0; n < 16; n++) begin
      overcurrent_low_level_sel <= 3'(n);
      overcurrent_high_level_sel <= n[3];
      pulse(1);
      e(2);
      chk(16'({ocHighLevelActive, ocLowLevelActive}), 16'(n));
    end
    // random drive with the logic supply lost
    logicSupplyOk <= 1'b0;
    for (n = 0; n < 8; n++) begin
      rnd = lfsr(rnd);
      e(1);
      direct_drive_inputs <= rnd[3:0];
      spiOutCmd <= rnd[7:4];
      payload <= rnd[14:0];
      e(4);
      chk(16'(switched_outputs), 16'(rnd[3:0]));
    end
    chk(16'(ocLowLevelActive), 16'(OcLowLevelDef));
    logicSupplyOk <= 1'b1;
    kickEn <= 1'b0; // no kick clears status mid-check
    spiOutCmd <= 4'h0;
    direct_drive_inputs <= 4'hF;
    // overvoltage holds off, bit cleared by read
    e(3);
    overVoltage <= 1'b1;
    e(4);
    chk(16'({switched_outputs, fault_flag_n}), 16'h00);
    overVoltage <= 1'b0;
    e(4);
    chk(16'({switched_outputs, overvoltage_fault_status,
             faultWord[OvFaultBit]}), 16'h3F);
    pulse(0);
    e(3);
    chk(16'({overvoltage_fault_status, faultWord[OvFaultBit]}), 16'h0);
    overvoltage_protect_off <= 1'b1;
    pulse(1);
    overVoltage <= 1'b1;
    e(4);
    chk(16'({switched_outputs, faultWord[OvWarnBit], overvoltageWarn}),
        16'h3F);
    overVoltage <= 1'b0;
    overvoltage_protect_off <= 1'b0;
    pulse(1);
    otherFault <= 1'b1;
    e(2);
    otherFault <= 1'b0;
    // high overcurrent latches until off then on
    ocHighLevelHit <= 4'h4;
    e(4);
    ocHighLevelHit <= 4'h0;
    e(4);
    chk(16'({switched_outputs, fault_flag_n}), 16'h16);
    reopen(4'h4);
    chk(16'({switched_outputs, fault_flag_n}), 16'h1F);
    // low overcurrent beyond the default time
    ocLowLevelHit <= 4'h8;
    e(int'(OcCycles0) - 20);
    chk(16'(switched_outputs), 16'hF);
    e(40);
    chk(16'(switched_outputs), 16'h7);
    ocLowLevelHit <= 4'h0;
    reopen(4'h8);
    pulse(0);
    overTemp <= 4'h1;
    e(4);
    overTemp <= 4'h0;
    e(4);
    chk(16'({switched_outputs, overtemp_fault_status[0],
             overcurrent_fault_status[0]}), 16'h3B);
    reopen(4'h1);
    overtemp_latch_cfg <= 4'h2;
    pulse(1);
    overTemp <= 4'h2;
    e(4);
    chk(16'({switched_outputs, overtemp_fault_status[1],
             overcurrent_fault_status[1]}), 16'h36);
    overTemp <= 4'h0;
    overTempHys <= 4'h2;
    e(4);
    chk(16'(switched_outputs), 16'hD);
    overTempHys <= 4'h0;
    e(4);
    chk(16'(switched_outputs), 16'hF);
    // timeout despite words without a toggle change
    kickEn <= 1'b1;
    e(70);
    overcurrent_low_level_sel <= 3'h5;
    pulse(1);
    kickEn <= 1'b0;
    for (n = 0; n < int'(WdCycles0) + 200 && watchdog_timeout_flag !== 1'b1;
         n++) begin
      e(1);
      readReq <= (n % 4096 == 100);
    end
    chk(16'(n > int'(WdCycles0) - 70 && n < int'(WdCycles0) + 10), 16'h1);
    e(3);
    chk(16'({faultWord[WdTimeoutBit], ocLowLevelActive}), 16'h8);
    for (n = 1; n < 4; n++) begin
      failsafe_select_input <= 2'(n);
      e(3);
      chk(16'(switched_outputs), 16'(pat(2'(n))));
    end
    wakeCmd <= 1'b0;
    e(4);
    chk(16'(watchdog_timeout_flag), 16'h0);
    failsafe_select_input <= FWS_SEL_GND;
    e(3);
    conclude();
  end
endmodule : tb_top
